// ---- hw/i2cm_pkg.sv ----
// Constants and types shared by the two-wire master
package i2cm_pkg;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_BAUD = 5'h04;
	localparam logic [4:0] OFF_ADDR = 5'h08;
	localparam logic [4:0] OFF_DATA = 5'h0c;
	localparam logic [4:0] OFF_CMD = 5'h10;
	localparam logic [4:0] OFF_STATUS = 5'h14;
	localparam int CNT_W = 9;
	localparam logic [8:0] STD_EXTRA = 9'h005;
	localparam logic [8:0] HS_EXTRA = 9'h001;
	localparam logic [1:0] BUS_UNKNOWN = 2'h0;
	localparam logic [1:0] BUS_IDLE = 2'h1;
	localparam logic [1:0] BUS_OWNER = 2'h2;
	localparam logic [1:0] BUS_BUSY = 2'h3;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam logic [1:0] CMD_STOP = 2'h3;
	localparam int STAT_MB = 0;
	localparam int STAT_SB = 1;
	localparam int STAT_ARB = 2;
	localparam int STAT_BERR = 3;
	localparam int STAT_BUS_LSB = 5;
	typedef struct packed {
		logic hs_mode;
		logic ack_action_select;
		logic stretch_strategy_select;
		logic auto_ack_mode_enable;
	} ctrl_t;
	localparam ctrl_t CTRL_RESET = 4'h0;
	typedef struct packed {
		logic [7:0] fast_low_count;
		logic [7:0] fast_high_count;
		logic [7:0] scl_low_count;
		logic [7:0] scl_high_count;
	} baud_t;
	localparam baud_t BAUD_RESET = 32'h0;
	typedef struct packed {
		logic received_nack_status;
		logic bus_error_status;
		logic arbitration_lost_status;
		logic slave_on_bus_flag;
		logic master_on_bus_flag;
	} status_t;
	localparam status_t STATUS_RESET = 5'h00;
endpackage

// ---- hw/line_sync.sv ----
// Two-flop synchroniser for the bus lines
`timescale 1ns/1ps
module line_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_reg;
	// Idle lines are pulled high, so reset to one
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				meta_reg[i] <= 1'b1;
				q_out[i] <= 1'b1;
			end else if (ce_in) begin
				meta_reg[i] <= d_in[i];
				q_out[i] <= meta_reg[i];
			end
		end
	end
endmodule

// ---- hw/i2cm_core.sv ----
// Two-wire master: serial clock, address phase and Avalon register slave
// How it works
// R1: Low period uses low count when non-zero, else the high count.
// R2: Stop set-up, bus free, start hold and restart set-up use low period.
// R3: High period always timed from the high count outside high-speed.
// R4: Low lasts low count plus 5 cycles; high lasts high count plus 5.
// R5: Low count zero: both phases use high count plus 5 cycles.
// R6: Fall counts as low; high timing starts once the line reads high.
// R7: Software keeps fast-plus ratio near 1 to 2, one count non-zero.
// R8: High-speed: no sync; low count zero gives both phases 1 plus count.
// R9: High-speed with low count: period 2 plus both counts.
// R10: Software sets stretch select before high-speed, ratio near 1 to 2.
// R11: Stretch select 0 holds before ack; 1 flags only after ack.
// R12: Address write starts; waits for idle bus, start then address.
// R13: Arbitration loss flags master and lost, releases lines until idle.
// R14: Bus error sets master flag, bus error and arbitration lost.
// R15: Received nack holds last real ack; loss and error leave it.
// R16: An address write in idle, hold or bus-free clears master status and interrupt flags.
// R17: Unacked address sets master flag and nack, holds clock low.
// R18: Software should stop after nack, or resend with repeated start.
// R19: Acked write address: master flag, nack clear, hold for next step.
// R20: New address during hold inserts a repeated start first.
// R21: Acked read address: receive byte, slave flag, nack clear, hold.
// R22: Auto mode: reading data acks and continues reading.
// R23: Auto mode: address or stop after byte sends ack action bit first.
// R24: Bus state: owner on start, busy on loss, idle after stop.
// R25: Phase counters restart at each line transition.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module i2cm_core
	import i2cm_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic sda_out,
	output logic sda_oe_out
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_WAIT_BUS, ST_START, ST_LOW, ST_HIGH, ST_HOLD,
		ST_RS_LOW, ST_RS_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_BUF
	} state_t;
	typedef enum logic [1:0] {NX_HOLD, NX_READ, NX_ADDR, NX_STOP} next_t;

	state_t state_reg;
	next_t next_reg;
	ctrl_t ctrl_reg;
	baud_t baud_reg;
	status_t stat_reg;
	logic [1:0] bus_reg;
	logic [7:0] addr_reg;
	logic [7:0] shift_reg;
	logic [7:0] rx_reg;
	logic [3:0] bit_reg;
	logic rx_mode_reg;
	logic is_addr_reg;
	logic ack_pend_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] low_len;
	logic [CNT_W-1:0] high_len;
	logic [7:0] low_base;
	logic [1:0] line_s;
	logic scl_s;
	logic sda_s;
	logic scl_q;
	logic sda_q;

	line_sync #(.WIDTH(2)) u_sync (
		.clk_in(ref_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.d_in({scl_in, sda_in}),
		.q_out(line_s)
	);
	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_in) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Bus access strobes, taken at the edge where waitrequest is low
	logic wr_acc;
	logic rd_acc;
	logic addr_wr;
	logic data_wr;
	logic data_rd;
	logic cmd_wr;
	logic stat_wr;
	logic [7:0] wd0;
	assign wr_acc = avs_write_in && !avs_waitrequest_out;
	assign rd_acc = avs_read_in && !avs_waitrequest_out;
	assign wd0 = avs_writedata_in[7:0];
	assign addr_wr = wr_acc && avs_address_in == OFF_ADDR && avs_byteenable_in[0]
		&& (state_reg == ST_IDLE || state_reg == ST_HOLD || state_reg == ST_STOP_BUF);
	assign data_wr = wr_acc && avs_address_in == OFF_DATA && avs_byteenable_in[0];
	assign cmd_wr = wr_acc && avs_address_in == OFF_CMD && avs_byteenable_in[0];
	assign stat_wr = wr_acc && avs_address_in == OFF_STATUS && avs_byteenable_in[0];
	assign data_rd = rd_acc && avs_address_in == OFF_DATA;

	// Phase lengths, loaded as length minus one
	always_comb begin
		if (ctrl_reg.hs_mode) begin
			low_base = (baud_reg.fast_low_count != 8'h00) ? baud_reg.fast_low_count
				: baud_reg.fast_high_count; // see R8 see R9
			low_len = {1'b0, low_base} + HS_EXTRA - 9'h001;
			high_len = {1'b0, baud_reg.fast_high_count} + HS_EXTRA - 9'h001;
		end else begin
			low_base = (baud_reg.scl_low_count != 8'h00) ? baud_reg.scl_low_count
				: baud_reg.scl_high_count; // see R1 see R5
			low_len = {1'b0, low_base} + STD_EXTRA - 9'h001; // see R4
			high_len = {1'b0, baud_reg.scl_high_count} + STD_EXTRA - 9'h001; // see R3
		end
	end

	// Bit events
	logic high_ok;
	logic tick_done;
	logic own_bit;
	logic drive_low;
	logic ev_lost;
	logic ev_berr;
	logic bit_fin;
	logic ev_ack;
	logic ev_mb;
	logic ev_sb;
	logic start_det;
	logic stop_det;
	// High-speed has no clock synchronisation, so it never waits on the line
	assign high_ok = ctrl_reg.hs_mode || scl_s; // see R6 see R8
	assign tick_done = cnt_reg == '0;
	assign own_bit = rx_mode_reg ? (bit_reg == 4'h8) : (bit_reg != 4'h8);
	assign drive_low = rx_mode_reg ? (bit_reg == 4'h8 && !ctrl_reg.ack_action_select)
		: (bit_reg != 4'h8 && !shift_reg[7]);
	assign ev_lost = state_reg == ST_HIGH && high_ok && tick_done && own_bit
		&& !sda_oe_out && !sda_s; // see R13
	assign ev_berr = state_reg == ST_HIGH && scl_s && scl_q && sda_s != sda_q; // see R14
	assign bit_fin = state_reg == ST_HIGH && high_ok && tick_done && !ev_lost && !ev_berr;
	assign ev_ack = bit_fin && !rx_mode_reg && bit_reg == 4'h8;
	assign ev_mb = (ev_ack && (sda_s || !is_addr_reg || !shift_reg[0]))
		|| ev_lost || ev_berr; // see R17 see R19
	assign ev_sb = bit_fin && rx_mode_reg && ((bit_reg == 4'h7 && !ctrl_reg.stretch_strategy_select)
		|| (bit_reg == 4'h8 && next_reg == NX_HOLD)); // see R11 see R21
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det = scl_s && scl_q && !sda_q && sda_s;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else if (ce_in) begin
			avs_waitrequest_out <= !(avs_waitrequest_out && (avs_read_in || avs_write_in));
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0;
		end else if (ce_in && avs_read_in && avs_waitrequest_out) begin
			case (avs_address_in)
				OFF_CTRL: avs_readdata_out <= {28'h0, ctrl_reg};
				OFF_BAUD: avs_readdata_out <= baud_reg;
				OFF_ADDR: avs_readdata_out <= {24'h0, addr_reg};
				OFF_DATA: avs_readdata_out <= {24'h0, rx_reg};
				OFF_STATUS: avs_readdata_out <= {25'h0, bus_reg, stat_reg};
				default: avs_readdata_out <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ctrl_reg <= CTRL_RESET;
			baud_reg <= BAUD_RESET;
			addr_reg <= 8'h00;
		end else if (ce_in) begin
			if (wr_acc && avs_address_in == OFF_CTRL && avs_byteenable_in[0]) begin
				ctrl_reg <= wd0[3:0];
			end
			if (wr_acc && avs_address_in == OFF_BAUD) begin
				for (int i = 0; i < 4; i++) begin
					if (avs_byteenable_in[i]) begin
						baud_reg[i*8 +: 8] <= avs_writedata_in[i*8 +: 8];
					end
				end
			end
			if (addr_wr) begin
				addr_reg <= wd0;
			end
		end
	end

	// Flags: sets are written last so an event beats a same-cycle clear
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			stat_reg <= STATUS_RESET;
		end else if (ce_in) begin
			if (addr_wr) begin
				stat_reg.master_on_bus_flag <= 1'b0; // see R16
				stat_reg.slave_on_bus_flag <= 1'b0;
				stat_reg.arbitration_lost_status <= 1'b0;
				stat_reg.bus_error_status <= 1'b0;
			end
			if (stat_wr) begin
				if (wd0[STAT_MB]) stat_reg.master_on_bus_flag <= 1'b0;
				if (wd0[STAT_SB]) stat_reg.slave_on_bus_flag <= 1'b0;
				if (wd0[STAT_ARB]) stat_reg.arbitration_lost_status <= 1'b0;
				if (wd0[STAT_BERR]) stat_reg.bus_error_status <= 1'b0;
			end
			if (ev_mb) stat_reg.master_on_bus_flag <= 1'b1;
			if (ev_lost || ev_berr) stat_reg.arbitration_lost_status <= 1'b1; // see R13
			if (ev_berr) stat_reg.bus_error_status <= 1'b1; // see R14
			if (ev_ack) stat_reg.received_nack_status <= sda_s; // see R15
			if (ev_sb) begin
				stat_reg.slave_on_bus_flag <= 1'b1; // see R21
				stat_reg.received_nack_status <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			bus_reg <= BUS_UNKNOWN;
		end else if (ce_in) begin
			if (ev_lost || ev_berr) begin
				bus_reg <= BUS_BUSY; // see R24
			end else if (state_reg == ST_WAIT_BUS && bus_reg == BUS_IDLE) begin
				bus_reg <= BUS_OWNER; // see R24
			end else if (stop_det) begin
				bus_reg <= BUS_IDLE;
			end else if (start_det && bus_reg != BUS_OWNER) begin
				bus_reg <= BUS_BUSY;
			end else if (stat_wr && bus_reg == BUS_UNKNOWN
				&& wd0[STAT_BUS_LSB +: 2] == BUS_IDLE) begin
				bus_reg <= BUS_IDLE;
			end
		end
	end

	// Open-drain lines: the output value is always low, enable pulls
	always_ff @(posedge ref_clk_in) begin
		scl_out <= 1'b0;
		sda_out <= 1'b0;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			next_reg <= NX_HOLD;
			cnt_reg <= '0;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
			shift_reg <= 8'h00;
			rx_reg <= 8'h00;
			bit_reg <= 4'h0;
			rx_mode_reg <= 1'b0;
			is_addr_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
		end else if (ce_in) begin
			if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
			unique case (state_reg)
				ST_IDLE: begin
					if (addr_wr) begin
						shift_reg <= wd0; // see R12
						state_reg <= ST_WAIT_BUS;
					end
				end
				ST_WAIT_BUS: begin
					if (bus_reg == BUS_IDLE) begin
						sda_oe_out <= 1'b1; // see R12
						cnt_reg <= low_len; // see R2
						state_reg <= ST_START;
					end
				end
				ST_START: begin
					if (tick_done) begin
						scl_oe_out <= 1'b1;
						bit_reg <= 4'h0;
						rx_mode_reg <= 1'b0;
						is_addr_reg <= 1'b1;
						cnt_reg <= low_len;
						state_reg <= ST_LOW;
					end
				end
				ST_LOW: begin
					sda_oe_out <= drive_low;
					if (tick_done) begin
						scl_oe_out <= 1'b0;
						cnt_reg <= high_len;
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (!high_ok) begin
						cnt_reg <= high_len; // see R6 see R25
					end else if (ev_lost || ev_berr) begin
						scl_oe_out <= 1'b0; // see R13
						sda_oe_out <= 1'b0;
						ack_pend_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end else if (tick_done) begin
						scl_oe_out <= 1'b1;
						cnt_reg <= low_len; // see R25
						state_reg <= ST_LOW;
						if (bit_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_reg <= bit_reg + 4'h1;
						end
						if (!rx_mode_reg && bit_reg == 4'h8) begin
							if (is_addr_reg && !sda_s && shift_reg[0]) begin
								rx_mode_reg <= 1'b1; // see R21
								next_reg <= NX_HOLD;
								bit_reg <= 4'h0;
							end else begin
								state_reg <= ST_HOLD; // see R17 see R19
							end
						end
						if (rx_mode_reg && bit_reg == 4'h7) begin
							rx_reg <= {shift_reg[6:0], sda_s};
							if (!ctrl_reg.stretch_strategy_select) begin
								ack_pend_reg <= 1'b1; // see R11
								state_reg <= ST_HOLD;
							end
						end
						if (rx_mode_reg && bit_reg == 4'h8) begin
							unique case (next_reg)
								NX_HOLD: state_reg <= ST_HOLD; // see R11
								NX_READ: bit_reg <= 4'h0;
								NX_ADDR: state_reg <= ST_RS_LOW;
								NX_STOP: state_reg <= ST_STOP_LOW;
							endcase
							next_reg <= NX_HOLD;
						end
					end
				end
				ST_HOLD: begin
					// Pending ack goes out before any new step
					if (addr_wr) begin
						shift_reg <= wd0;
						if (ack_pend_reg) begin
							next_reg <= NX_ADDR; // see R23
							state_reg <= ST_LOW;
						end else begin
							state_reg <= ST_RS_LOW; // see R20
						end
						ack_pend_reg <= 1'b0;
						cnt_reg <= low_len;
					end else if (cmd_wr && wd0[1:0] == CMD_STOP) begin
						if (ack_pend_reg) begin
							next_reg <= NX_STOP; // see R23
							state_reg <= ST_LOW;
						end else begin
							state_reg <= ST_STOP_LOW;
						end
						ack_pend_reg <= 1'b0;
						cnt_reg <= low_len;
					end else if (rx_mode_reg && ((data_rd && ctrl_reg.auto_ack_mode_enable)
						|| (cmd_wr && wd0[1:0] == CMD_READ))) begin
						if (ack_pend_reg) begin
							next_reg <= NX_READ; // see R22
						end else begin
							bit_reg <= 4'h0;
						end
						ack_pend_reg <= 1'b0;
						cnt_reg <= low_len;
						state_reg <= ST_LOW;
					end else if (!rx_mode_reg && data_wr) begin
						shift_reg <= wd0; // see R19
						bit_reg <= 4'h0;
						is_addr_reg <= 1'b0;
						cnt_reg <= low_len;
						state_reg <= ST_LOW;
					end
				end
				ST_RS_LOW: begin
					sda_oe_out <= 1'b0;
					if (tick_done) begin
						scl_oe_out <= 1'b0;
						cnt_reg <= low_len; // see R2
						state_reg <= ST_RS_HIGH;
					end
				end
				ST_RS_HIGH: begin
					if (!high_ok) begin
						cnt_reg <= low_len;
					end else if (tick_done) begin
						sda_oe_out <= 1'b1; // see R20
						cnt_reg <= low_len;
						state_reg <= ST_START;
					end
				end
				ST_STOP_LOW: begin
					sda_oe_out <= 1'b1;
					if (tick_done) begin
						scl_oe_out <= 1'b0;
						cnt_reg <= low_len;
						state_reg <= ST_STOP_HIGH;
					end
				end
				ST_STOP_HIGH: begin
					if (!high_ok) begin
						cnt_reg <= low_len;
					end else if (tick_done) begin
						sda_oe_out <= 1'b0; // see R2
						cnt_reg <= low_len;
						state_reg <= ST_STOP_BUF;
					end
				end
				ST_STOP_BUF: begin
					// Address taken during bus-free time starts once that time is up
					if (addr_wr) begin
						shift_reg <= wd0; // see R12
						next_reg <= NX_ADDR;
					end
					if (tick_done) begin
						state_reg <= (addr_wr || next_reg == NX_ADDR) ? ST_WAIT_BUS : ST_IDLE; // see R2
						next_reg <= NX_HOLD;
					end
				end
			endcase
		end
	end

	// Cycle age of the current phase, one less than cycles spent in it
	logic [CNT_W-1:0] age_reg;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			age_reg <= '0;
		end else if (ce_in) begin
			if (state_reg == ST_HIGH && !high_ok) begin
				age_reg <= '0;
			end else if (state_reg != $past(state_reg)) begin
				age_reg <= CNT_W'(1);
			end else begin
				age_reg <= age_reg + 1'b1;
			end
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in || !ce_in);

	sequence s_ack_slot;
		state_reg == ST_LOW && bit_reg == 4'h8 && rx_mode_reg;
	endsequence
	sequence s_ack_driven;
		sda_oe_out == !ctrl_reg.ack_action_select;
	endsequence

	a_low_phase_len: assert property ( // see R1 see R4 see R5
		($past(state_reg) == ST_LOW && state_reg == ST_HIGH && !ctrl_reg.hs_mode)
		|-> $past(age_reg) == CNT_W'(baud_reg.scl_low_count != 8'h00 ?
			baud_reg.scl_low_count : baud_reg.scl_high_count) + 9'd4)
		else $error("low phase length wrong");
	a_high_phase_len: assert property ( // see R3 see R6
		($past(state_reg) == ST_HIGH && state_reg == ST_LOW && !ctrl_reg.hs_mode)
		|-> $past(age_reg) == CNT_W'(baud_reg.scl_high_count) + 9'd4)
		else $error("high phase length wrong");
	a_hs_period: assert property ( // see R8 see R9
		($past(state_reg) == ST_HIGH && state_reg == ST_LOW && ctrl_reg.hs_mode)
		|-> $past(age_reg) == CNT_W'(baud_reg.fast_high_count))
		else $error("high-speed high phase wrong");
	a_wait_idle: assert property ( // see R12
		(state_reg == ST_WAIT_BUS && bus_reg != BUS_IDLE) |=> state_reg == ST_WAIT_BUS
		&& !sda_oe_out && !scl_oe_out)
		else $error("start issued on non-idle bus");
	a_arb_release: assert property ( // see R13
		ev_lost && !ev_berr |=> !scl_oe_out && !sda_oe_out
		&& stat_reg.arbitration_lost_status && stat_reg.master_on_bus_flag
		&& bus_reg == BUS_BUSY)
		else $error("arbitration loss not handled");
	a_berr_flags: assert property ( // see R14
		ev_berr |=> stat_reg.bus_error_status && stat_reg.arbitration_lost_status
		&& stat_reg.master_on_bus_flag)
		else $error("bus error flags missing");
	a_nack_keep: assert property ( // see R15
		(ev_lost || ev_berr) |=> $stable(stat_reg.received_nack_status))
		else $error("nack changed on loss");
	a_addr_clears: assert property ( // see R16
		(addr_wr && !ev_mb && !ev_sb) |=> !stat_reg.master_on_bus_flag
		&& !stat_reg.slave_on_bus_flag && !stat_reg.arbitration_lost_status
		&& !stat_reg.bus_error_status)
		else $error("address write left flags set");
	a_nack_hold: assert property ( // see R17
		(ev_ack && sda_s) |=> state_reg == ST_HOLD && scl_oe_out
		&& stat_reg.received_nack_status && stat_reg.master_on_bus_flag)
		else $error("unacked address not held");
	a_rstart_ins: assert property ( // see R20
		(state_reg == ST_HOLD && addr_wr && !ack_pend_reg) |=> state_reg == ST_RS_LOW
		##[1:600] state_reg == ST_START)
		else $error("no repeated start");
	a_auto_ack: assert property ( // see R22 see R23
		(state_reg == ST_HOLD && ack_pend_reg && rx_mode_reg
		&& data_rd && ctrl_reg.auto_ack_mode_enable) |=> s_ack_slot ##1 s_ack_driven)
		else $error("auto ack not sent");
	a_bus_owner: assert property ( // see R24
		(state_reg == ST_WAIT_BUS && bus_reg == BUS_IDLE && !ev_lost)
		|=> bus_reg == BUS_OWNER && state_reg == ST_START)
		else $error("bus state not owner at start");
endmodule

// ---- tb/i2c_slave_model.sv ----
// Behavioural two-wire slave: acks one address, returns a fixed byte on reads
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] RDATA = 8'h96
) (
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_out
);
	logic [7:0] sh;
	logic rd;
	logic act;
	int n;
	initial begin
		sda_oe_out = 1'b0;
		act = 1'b0;
		rd = 1'b0;
		sh = 8'h00;
		n = 0;
	end
	// Start or repeated start
	always @(negedge sda_in) if (scl_in === 1'b1) begin
		act = 1'b1;
		rd = 1'b0;
		n = 0;
		sda_oe_out = 1'b0;
	end
	always @(posedge sda_in) if (scl_in === 1'b1) begin
		act = 1'b0;
		sda_oe_out = 1'b0;
	end
	always @(posedge scl_in) if (act) begin
		if (n < 8 && !rd)
			sh = {sh[6:0], sda_in};
		// Master nack ends the read
		if (n == 8 && rd && sda_in)
			act = 1'b0;
		n = n + 1;
	end
	// Changes only while the clock is low, so no false start or stop
	always @(negedge scl_in) if (act) begin
		if (n == 9)
			n = 0;
		if (rd && n < 8)
			sda_oe_out = !RDATA[7 - n];
		else if (n == 8 && !rd) begin
			sda_oe_out = (sh[7:1] == ADDR);
			act = (sh[7:1] == ADDR);
			rd = sh[0];
		end else
			sda_oe_out = 1'b0;
	end
endmodule

// ---- tb/i2cm_core_tb.sv ----
// Self-checking bench for the two-wire master
`timescale 1ns/1ps
module i2cm_core_tb;
	import i2cm_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic arb_oe = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic [31:0] rd_out;
	logic wreq, scl_oe, sda_oe, scl_o, sda_o, slv_oe;
	logic [7:0] h, l, fh, fl;
	int mismatches = 0;
	int n_tests = 0;
	int starts = 0;
	int lo, hi, w;
	// Pull-ups on both lines
	wire logic scl = !scl_oe;
	wire logic sda = !(sda_oe | slv_oe | arb_oe);
	initial forever #2.5 ref_clk_in = ~ref_clk_in;
	i2cm_core uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(1'b1),
		.avs_address_in(addr), .avs_read_in(rd_req), .avs_write_in(wr_req),
		.avs_byteenable_in(4'hf), .avs_writedata_in(wdata), .avs_readdata_out(rd_out),
		.avs_waitrequest_out(wreq), .scl_in(scl), .sda_in(sda), .scl_out(scl_o),
		.scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe));
	i2c_slave_model #(.ADDR(7'h2a), .RDATA(8'h96)) slave (.scl_in(scl), .sda_in(sda),
		.sda_oe_out(slv_oe));
	always @(negedge sda) if (scl === 1'b1) starts++;
	task tally_and_finish;
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task bail;
		mismatches++;
		$display("MISMATCH wait expected done seen timeout");
		tally_and_finish();
	endtask
	task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk_in);
		rd_req <= !wr;
		wr_req <= wr;
		addr <= a;
		wdata <= d;
		i = 0;
		do begin
			@(posedge ref_clk_in);
			i++;
		end while (wreq !== 1'b0 && i < 100);
		if (i >= 100)
			bail();
		rdata = rd_out;
		rd_req <= 1'b0;
		wr_req <= 1'b0;
	endtask
	task wait_stat(input logic [31:0] m, input logic [31:0] v);
		int i;
		i = 0;
		do begin
			av(1'b0, OFF_STATUS, 32'h0);
			i++;
		end while ((rdata & m) !== v && i < 3000);
		if (i >= 3000)
			bail();
	endtask
	task runlen(input logic lvl, output int n);
		int i;
		n = 0;
		i = 0;
		while (scl_oe !== lvl && i < 5000) begin
			@(posedge ref_clk_in);
			i++;
		end
		while (scl_oe === lvl && i < 5000) begin
			@(posedge ref_clk_in);
			n++;
			i++;
		end
		if (i >= 5000)
			bail();
	endtask
	function automatic int exp_len(input logic hs, input logic low, input logic [7:0] c,
		input logic [7:0] lc);
		if (hs)
			return low ? 1 + int'((lc != 8'h00) ? lc : c) : 1 + int'(c);
		// Two extra cycles: the high phase waits for the synchronised line
		return low ? int'((lc != 8'h00) ? lc : c) + 5 : int'(c) + 7;
	endfunction
	initial begin
		q = $urandom(32'hf8bf);
		repeat (16) @(posedge ref_clk_in);
		chk("reset outputs", 32'h4, {27'h0, scl_o, sda_o, wreq, scl_oe, sda_oe});
		chk("reset readdata", 32'h0, rd_out);
		rst_in <= 1'b0;
		av(1'b0, OFF_STATUS, 32'h0);
		chk("bus unknown", 32'(BUS_UNKNOWN), 32'(rdata[6:5]));
		av(1'b1, OFF_STATUS, 32'h20);
		for (int k = 0; k < 4; k++) begin
			h = 8'h04 + 8'($urandom % 12);
			l = k[0] ? 8'h04 + 8'($urandom % 20) : 8'h00;
			fh = 8'h03 + 8'($urandom % 8);
			fl = k[0] ? 8'h03 + 8'($urandom % 8) : 8'h00;
			av(1'b1, OFF_CTRL, {28'h0, k[1], 3'b010});
			av(1'b1, OFF_BAUD, {fl, fh, l, h});
			av(1'b1, OFF_ADDR, {24'h0, 7'h2a, 1'b0});
			runlen(1'b1, lo);
			runlen(1'b0, hi);
			runlen(1'b1, lo);
			runlen(1'b0, hi);
			w = exp_len(k[1], 1'b1, k[1] ? fh : h, k[1] ? fl : l);
			chk("low phase", 32'(w), 32'(lo));
			w = exp_len(k[1], 1'b0, k[1] ? fh : h, k[1] ? fl : l);
			chk("high phase", 32'(w), 32'(hi));
			wait_stat(32'h1, 32'h1);
			chk("acked write", 32'({BUS_OWNER, 5'h01}), 32'(rdata[6:0]));
			chk("clock hold", 32'h1, 32'(scl_oe));
			av(1'b1, OFF_ADDR, {24'h0, 7'h33, 1'b0});
			wait_stat(32'h1, 32'h1);
			chk("unacked", 32'({BUS_OWNER, 5'h11}), 32'(rdata[6:0]));
			chk("held after nack", 32'h1, 32'(scl_oe));
			chk("start count", 32'(2 * k + 2), 32'(starts));
			av(1'b1, OFF_CMD, {30'h0, CMD_STOP});
			wait_stat(32'h60, 32'h20);
		end
		// Auto ack read of two bytes, both acked before the stop
		av(1'b1, OFF_CTRL, 32'h3);
		av(1'b1, OFF_ADDR, {24'h0, 7'h2a, 1'b1});
		wait_stat(32'h2, 32'h2);
		chk("acked read", 32'h2, 32'(rdata[4:0]));
		av(1'b1, OFF_STATUS, 32'h2);
		av(1'b0, OFF_DATA, 32'h0);
		chk("first byte", 32'h96, 32'(rdata[7:0]));
		wait_stat(32'h2, 32'h2);
		av(1'b1, OFF_CTRL, 32'h7);
		av(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_stat(32'h60, 32'h20);
		av(1'b0, OFF_DATA, 32'h0);
		chk("second byte", 32'h96, 32'(rdata[7:0]));
		// Hold before the ack: auto ack on a data read, then nack and stop
		av(1'b1, OFF_CTRL, 32'h1);
		av(1'b1, OFF_ADDR, {24'h0, 7'h2a, 1'b1});
		wait_stat(32'h2, 32'h2);
		chk("held before ack", 32'h1, 32'(scl_oe));
		av(1'b1, OFF_STATUS, 32'h2);
		av(1'b0, OFF_DATA, 32'h0);
		chk("held byte", 32'h96, 32'(rdata[7:0]));
		wait_stat(32'h2, 32'h2);
		av(1'b1, OFF_CTRL, 32'h5);
		av(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_stat(32'h60, 32'h20);
		// Another master holds data low through the address
		av(1'b1, OFF_CTRL, 32'h0);
		av(1'b1, OFF_ADDR, {24'h0, 7'h55, 1'b0});
		w = 0;
		while (sda_oe !== 1'b1 && w < 2000) begin
			@(posedge ref_clk_in);
			w++;
		end
		if (w >= 2000)
			bail();
		arb_oe <= 1'b1;
		wait_stat(32'h1, 32'h1);
		chk("arb lost", 32'({BUS_BUSY, 5'h05}), 32'(rdata[6:0]));
		chk("lines released", 32'h0, {30'h0, scl_oe, sda_oe});
		arb_oe <= 1'b0;
		wait_stat(32'h60, 32'h20);
		av(1'b1, OFF_ADDR, {24'h0, 7'h55, 1'b0});
		av(1'b0, OFF_STATUS, 32'h0);
		chk("flags cleared", 32'h0, 32'(rdata[3:0]));
		// Data pulled low inside a high phase reads as a bus error
		runlen(1'b1, lo);
		repeat (4) @(posedge ref_clk_in);
		arb_oe <= 1'b1;
		wait_stat(32'h8, 32'h8);
		chk("bus error", 32'({BUS_BUSY, 5'h0d}), 32'(rdata[6:0]));
		chk("released on error", 32'h0, {30'h0, scl_oe, sda_oe});
		arb_oe <= 1'b0;
		wait_stat(32'h60, 32'h20);
		tally_and_finish();
	end
endmodule
